// ### hdl/dce_pkg.sv
// Function
// - each channel owns readable gain and zero registers
// - corrected code is input times gain plus zero
// - input, gain or zero write recorrects the channel
// - gain coefficient spans one half to one and half
// - zero offset spans minus 2048 to plus 2047
// - one shared datapath serves all eight channels
// - writing input, gain or zero sets channel busy
// - channel busy clears once result is stored
// - one correction takes about 500 ns
// - fixed priority, channel 0 first, 7 last
// - engine running: global busy set, pin low
// - engine disabled: global busy zero, pin released
// - host writes freely when global busy is clear
// - host writes a channel whose busy is clear
// - host may pace writes by 500 ns each
// - host waits for channel and higher priorities
// - enable bit turns correction on, resets to zero
// - disabled: input copied straight to data register
// - disabled: gain or zero writes start nothing
// - gain and zero read back as written
// - code is input times gain plus 2048, over 4096
// - gain resets to 2048, zero resets to zero
// - gain is unsigned binary, zero twos complement
package dce_pkg;
  localparam int CODE_W = 12;
  localparam int NCH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 5;
  localparam int HCLK_MHZ = 20;
  localparam int CORR_NS = 500;
  localparam int CORR_CYC = (CORR_NS * HCLK_MHZ) / 1000;
  localparam logic [4:0] CNT_LAST = 5'(CORR_CYC - 1);
  localparam logic [11:0] GAIN_RST = 12'h800;
  localparam logic [11:0] ZERO_RST = 12'h000;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam int GAIN_HALF = 2048;
  localparam int FRAC_SH = 12;
  // device register map: bits 4:3 select the kind, 2:0 the channel
  localparam logic [1:0] KIND_INPUT = 2'h0;
  localparam logic [1:0] KIND_GAIN = 2'h1;
  localparam logic [1:0] KIND_ZERO = 2'h2;
  localparam logic [1:0] KIND_MISC = 2'h3;
  localparam logic [2:0] MISC_CFG = 3'h0;
  localparam logic [2:0] MISC_BUSY = 3'h1;
  localparam int CFG_EN_BIT = 0;
  localparam int GBF_BIT = 8;
  // controller registers on AHB-Lite
  localparam logic [7:0] CTL_CMD = 8'h00;
  localparam logic [7:0] CTL_WDATA = 8'h04;
  localparam logic [7:0] CTL_RDATA = 8'h08;
  localparam logic [7:0] CTL_STAT = 8'h0c;
  localparam int CMD_GO_BIT = 31;
  localparam int CMD_RD_BIT = 30;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### hdl/dce_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dce_link_if;
  logic cs;
  logic wr;
  logic [4:0] addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic busy_n_o;
  logic busy_n_oe_n;
  modport dev (input cs, input wr, input addr, input wdata,
               output rdata, output busy_n_o, output busy_n_oe_n);
  modport host (output cs, output wr, output addr, output wdata,
                input rdata, input busy_n_o, input busy_n_oe_n);
endinterface
`default_nettype wire

// ### hdl/dce_math.sv
`timescale 1ns/1ns
`default_nettype none
module dce_math
  import dce_pkg::*;
(
  input wire logic [11:0] in_code,
  input wire logic [11:0] gain,
  input wire logic [11:0] zero,
  output logic [11:0] result
);
  logic [12:0] coef;
  logic [24:0] prod;
  logic signed [14:0] sum;
  always_comb begin
    coef = 13'(gain) + 13'(GAIN_HALF);
    prod = 25'(in_code) * 25'(coef);
    sum = 15'(signed'({1'b0, prod[24:FRAC_SH]}))
          + 15'(signed'(zero));
    if (sum < 0) begin
      result = '0;
    end else if (sum > 15'(CODE_MAX)) begin
      result = CODE_MAX;
    end else begin
      result = sum[11:0];
    end
  end
endmodule // dce_math
`default_nettype wire

// ### hdl/dce_dev.sv
`timescale 1ns/1ns
`default_nettype none
module dce_dev
  import dce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  dce_link_if.dev link,
  output logic [11:0] dac_data [NCH],
  output logic engine_run
);
  typedef enum logic [0:0] {IDLE = 1'b0, RUN = 1'b1} dce_st_type;
  dce_st_type st_r;
  logic [11:0] in_r [NCH];
  logic [11:0] gain_r [NCH];
  logic [11:0] zero_r [NCH];
  logic [NCH-1:0] bf_r;
  logic en_r;
  logic [2:0] ch_r;
  logic [4:0] cnt_r;
  logic [11:0] rdata_r;
  logic [11:0] res;
  logic [2:0] pick;
  logic wr_stb;
  logic [1:0] kind;
  logic [2:0] wch;
  logic done;

  function automatic logic [2:0] first_set(input logic [NCH-1:0] v);
    first_set = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  assign wr_stb = link.cs && link.wr && clk_en;
  assign kind = link.addr[4:3];
  assign wch = link.addr[2:0];
  assign pick = first_set(bf_r);
  assign done = (st_r == RUN) && (cnt_r == CNT_LAST) && clk_en;

  // one shared datapath, muxed by the channel in service
  dce_math dce_math_inst (
    .in_code(in_r[ch_r]),
    .gain(gain_r[ch_r]),
    .zero(zero_r[ch_r]),
    .result(res)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
    end else if (wr_stb && kind == KIND_MISC && wch == MISC_CFG) begin
      en_r <= link.wdata[CFG_EN_BIT];
    end
  end

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          in_r[c] <= '0;
          gain_r[c] <= GAIN_RST;
          zero_r[c] <= ZERO_RST;
        end else if (wr_stb && wch == 3'(c)) begin
          if (kind == KIND_INPUT) begin
            in_r[c] <= link.wdata;
          end
          if (kind == KIND_GAIN) begin
            gain_r[c] <= link.wdata;
          end
          if (kind == KIND_ZERO) begin
            zero_r[c] <= link.wdata;
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          bf_r[c] <= 1'b0;
        end else if (!en_r) begin
          bf_r[c] <= 1'b0;
        end else if (wr_stb && wch == 3'(c) && kind != KIND_MISC) begin
          bf_r[c] <= 1'b1;
        end else if (done && ch_r == 3'(c)) begin
          bf_r[c] <= 1'b0;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dac_data[c] <= '0;
        end else if (!en_r && wr_stb && wch == 3'(c)
                     && kind == KIND_INPUT) begin
          dac_data[c] <= link.wdata;
        end else if (done && ch_r == 3'(c)) begin
          dac_data[c] <= res;
        end
      end
    end
  endgenerate

  // a rewrite of the channel in service during its run is the host's
  // fault; the flag still clears at done and the result uses the new value, unless the write lands in the done cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= IDLE;
      ch_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      unique case (st_r)
        IDLE: begin
          cnt_r <= '0;
          if (en_r && |bf_r) begin
            st_r <= RUN;
            ch_r <= pick;
          end
        end
        RUN: begin
          if (cnt_r == CNT_LAST) begin
            st_r <= IDLE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      engine_run <= 1'b0;
      link.busy_n_o <= 1'b1;
      link.busy_n_oe_n <= 1'b1;
    end else if (clk_en) begin
      engine_run <= en_r && (|bf_r || st_r == RUN);
      link.busy_n_o <= !(en_r && (|bf_r || st_r == RUN));
      link.busy_n_oe_n <= !en_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= '0;
    end else if (clk_en) begin
      unique case (kind)
        KIND_INPUT: rdata_r <= in_r[wch];
        KIND_GAIN: rdata_r <= gain_r[wch];
        KIND_ZERO: rdata_r <= zero_r[wch];
        KIND_MISC: begin
          if (wch == MISC_CFG) begin
            rdata_r <= {11'h000, en_r};
          end else if (wch == MISC_BUSY) begin
            // global flag forced to zero while disabled
            rdata_r <= {3'h0, en_r && (|bf_r || st_r == RUN), bf_r};
          end else begin
            rdata_r <= '0;
          end
        end
      endcase
    end
  end
  assign link.rdata = rdata_r;
endmodule // dce_dev
`default_nettype wire

// ### hdl/dce_host.sv
`timescale 1ns/1ns
`default_nettype none
module dce_host
  import dce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  dce_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01,
                            H_ACC = 2'b11, H_CAP = 2'b10} dce_hst_type;
  dce_hst_type st_r;
  logic [31:0] cmd_r;
  logic [11:0] wd_r;
  logic [11:0] rd_r;
  logic dph_r;
  logic dwr_r;
  logic [7:0] da_r;
  logic bsy_s1_r;
  logic bsy_s2_r;
  logic go;

  assign go = dph_r && dwr_r && da_r == CTL_CMD && hwdata[CMD_GO_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      da_r <= '0;
    end else if (clk_en) begin
      dph_r <= hsel && hready && htrans == HTRANS_NONSEQ;
      dwr_r <= hwrite;
      da_r <= haddr[7:0];
    end
  end

  // busy pin comes from another chip: two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsy_s1_r <= 1'b1;
      bsy_s2_r <= 1'b1;
    end else if (clk_en) begin
      bsy_s1_r <= link.busy_n_oe_n ? 1'b1 : link.busy_n_o;
      bsy_s2_r <= bsy_s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= '0;
      wd_r <= '0;
    end else if (clk_en && dph_r && dwr_r) begin
      if (da_r == CTL_CMD && st_r == H_IDLE) begin
        cmd_r <= hwdata;
      end
      if (da_r == CTL_WDATA) begin
        wd_r <= hwdata[11:0];
      end
    end
  end

  // the host waits for a released busy pin before any device write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= H_IDLE;
      rd_r <= '0;
      link.cs <= 1'b0;
      link.wr <= 1'b0;
      link.addr <= '0;
      link.wdata <= '0;
    end else if (clk_en) begin
      unique case (st_r)
        H_IDLE: if (go) st_r <= H_WAIT;
        H_WAIT: begin
          // waiting for the released pin spaces writes one correction apart, unless go comes in the first H_IDLE cycle after a write
          if (cmd_r[CMD_RD_BIT] || bsy_s2_r) begin
            st_r <= H_ACC;
            link.cs <= 1'b1;
            link.wr <= !cmd_r[CMD_RD_BIT];
            link.addr <= cmd_r[4:0];
            link.wdata <= wd_r;
          end
        end
        H_ACC: begin
          link.cs <= 1'b0;
          link.wr <= 1'b0;
          st_r <= H_CAP;
        end
        H_CAP: begin
          rd_r <= link.rdata;
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (clk_en && hsel && hready && htrans == HTRANS_NONSEQ) begin
      unique case (haddr[7:0])
        CTL_CMD: hrdata <= cmd_r;
        CTL_WDATA: hrdata <= {20'h00000, wd_r};
        CTL_RDATA: hrdata <= {20'h00000, rd_r};
        CTL_STAT: hrdata <= {30'h00000000, bsy_s2_r, st_r != H_IDLE};
        default: hrdata <= '0;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // dce_host
`default_nettype wire

// ### dv/dce_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dce_chk
  import dce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [11:0] wdata,
  input wire logic [11:0] rdata,
  input wire logic busy_n_o,
  input wire logic busy_n_oe_n
);
  logic en_r;
  logic [11:0] gain_r [NCH];
  logic [11:0] zero_r [NCH];
  wire wr_stb = cs & wr;
  wire rd_stb = cs & ~wr;
  // mirrors of what was written, so reads can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
    end else if (wr_stb && addr == {KIND_MISC, MISC_CFG}) begin
      en_r <= wdata[CFG_EN_BIT];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_r <= '{default: GAIN_RST};
      zero_r <= '{default: ZERO_RST};
    end else if (wr_stb && addr[4:3] == KIND_GAIN) begin
      gain_r[addr[2:0]] <= wdata;
    end else if (wr_stb && addr[4:3] == KIND_ZERO) begin
      zero_r[addr[2:0]] <= wdata;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence run_hold_s;
    !busy_n_o [*8];
  endsequence
  sequence run_end_s;
    ##[1:5] busy_n_o;
  endsequence
  busy_dis_a: assert property (!en_r && !$past(en_r) |-> busy_n_oe_n)
    else $error("busy pin driven with correction off");
  busy_drv_a: assert property (en_r && $past(en_r) |-> !busy_n_oe_n)
    else $error("busy pin not driven with correction on");
  busy_start_a: assert property (en_r && wr_stb &&
    addr[4:3] != KIND_MISC |-> ##2 !busy_n_o)
    else $error("busy pin not low after write");
  corr_len_a: assert property ($fell(busy_n_o) |-> run_hold_s)
    else $error("correction shorter than expected");
  corr_end_a: assert property ($fell(busy_n_o) |-> ##8 run_end_s)
    else $error("busy pin not released after correction");
  gain_read_a: assert property (rd_stb && addr[4:3] == KIND_GAIN
    |=> rdata == gain_r[$past(addr[2:0])])
    else $error("gain read back wrong");
  zero_read_a: assert property (rd_stb && addr[4:3] == KIND_ZERO
    |=> rdata == zero_r[$past(addr[2:0])])
    else $error("zero read back wrong");
  busy_idle_a: assert property (rd_stb && addr == {KIND_MISC, MISC_BUSY}
    && busy_n_o && $past(busy_n_o) |=> rdata[8:0] == 9'h000)
    else $error("busy flags set while idle");
endmodule // dce_chk
`default_nettype wire

// ### dv/dac_calibration_engine_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dac_calibration_engine_tb_top
  import dce_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [11:0] dac_data [NCH];
  logic engine_run;
  logic [31:0] rv;
  int num_errors = 0;
  int checked = 0;
  // {channel, gain, zero, input}: half gain, top gain, both clamps
  logic [38:0] tv [4] = '{{3'h0, 12'h000, 12'h000, 12'hfff},
    {3'h2, 12'hfff, 12'h000, 12'h800}, {3'h5, 12'h800, 12'h800, 12'h100},
    {3'h7, 12'hfff, 12'h7ff, 12'hfff}};
  dce_link_if link ();
  always #25 hclk = ~hclk;
  dce_dev dce_dev_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .link(link.dev), .dac_data(dac_data), .engine_run(engine_run));
  dce_host dce_host_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(link.host));
  dce_chk dce_chk_inst (.hclk(hclk), .hresetn(hresetn), .cs(link.cs),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .busy_n_o(link.busy_n_o), .busy_n_oe_n(link.busy_n_oe_n));
  task automatic end_sim();
    $display("checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    end_sim();
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) tmo();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic dev(input logic w, input logic [4:0] a,
                     input logic [11:0] d, output logic [31:0] q);
    int n;
    n = 0;
    if (w) ahb(1'b1, CTL_WDATA, {20'h0, d}, q);
    ahb(1'b1, CTL_CMD, {1'b1, ~w, 25'h0, a}, q);
    do begin
      ahb(1'b0, CTL_STAT, '0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (q[0] !== 1'b0) tmo();
    if (!w) ahb(1'b0, CTL_RDATA, '0, q);
  endtask
  task automatic idle();
    int n;
    repeat (3) @(posedge hclk);
    for (n = 0; n < 60 && engine_run !== 1'b0; n++) @(posedge hclk);
    if (engine_run !== 1'b0) tmo();
  endtask
  // truncating divide, then clamp to the code range
  function automatic logic [11:0] corr(input logic [11:0] x,
      input logic [11:0] g, input logic [11:0] z);
    int v;
    v = (int'(x) * (int'(g) + GAIN_HALF)) / 4096 + int'(signed'(z));
    return (v < 0) ? 12'h000 : (v > 4095) ? CODE_MAX : v[11:0];
  endfunction
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int c = 0; c < NCH; c++) begin
      dev(1'b0, {KIND_GAIN, 3'(c)}, '0, rv);
      chk(rv[11:0], GAIN_RST);
      dev(1'b0, {KIND_ZERO, 3'(c)}, '0, rv);
      chk(rv[11:0], ZERO_RST);
    end
    dev(1'b0, {KIND_MISC, MISC_CFG}, '0, rv);
    chk(rv[11:0], 12'h000);
    $display("test reset done");
    dev(1'b1, {KIND_INPUT, 3'h3}, 12'h123, rv);
    chk(dac_data[3], 12'h123);
    dev(1'b1, {KIND_GAIN, 3'h3}, 12'habc, rv);
    dev(1'b1, {KIND_ZERO, 3'h3}, 12'hf00, rv);
    chk(link.busy_n_oe_n, 1'b1);
    dev(1'b0, {KIND_MISC, MISC_BUSY}, '0, rv);
    chk(rv[11:0], 12'h000);
    dev(1'b0, {KIND_GAIN, 3'h3}, '0, rv);
    chk(rv[11:0], 12'habc);
    chk(dac_data[3], 12'h123);
    $display("test bypass done");
    dev(1'b1, {KIND_MISC, MISC_CFG}, 12'h001, rv);
    foreach (tv[i]) begin
      dev(1'b1, {KIND_GAIN, tv[i][38:36]}, tv[i][35:24], rv);
      dev(1'b1, {KIND_ZERO, tv[i][38:36]}, tv[i][23:12], rv);
      dev(1'b1, {KIND_INPUT, tv[i][38:36]}, tv[i][11:0], rv);
      idle();
      chk(dac_data[tv[i][38:36]], corr(tv[i][11:0], tv[i][35:24],
        tv[i][23:12]));
    end
    dev(1'b1, {KIND_ZERO, 3'h2}, 12'h001, rv);
    idle();
    chk(dac_data[2], 12'hc00);
    $display("test math done");
    dev(1'b1, {KIND_INPUT, 3'h6}, 12'h456, rv);
    repeat (2) @(posedge hclk);
    chk(engine_run, 1'b1);
    chk(link.busy_n_o, 1'b0);
    dev(1'b0, {KIND_MISC, MISC_BUSY}, '0, rv);
    chk(rv[11:0], 12'h140);
    idle();
    dev(1'b0, {KIND_MISC, MISC_BUSY}, '0, rv);
    chk(rv[11:0], 12'h000);
    chk(dac_data[6], corr(12'h456, GAIN_RST, ZERO_RST));
    dev(1'b1, {KIND_MISC, MISC_CFG}, 12'h000, rv);
    repeat (2) @(posedge hclk);
    chk(link.busy_n_oe_n, 1'b1);
    $display("test busy done");
    end_sim();
  end
endmodule // dac_calibration_engine_tb_top
`default_nettype wire
